// File: include/acm_map.svh
// register offsets, field positions, reset values for the acs control and multicast capability bank
// assumes byte offsets within the function's configuration space
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH

`define ACM_ADDR_W          12
`define ACM_OFF_ACS_CTL     12'h326
`define ACM_OFF_MC_HDR      12'h330
`define ACM_OFF_MC_CAP      12'h334
`define ACM_OFF_MODE_CFG    12'h3F0
`define ACM_OFF_LOCK        12'h3F4

`define ACM_BIT_SRC_VAL     0
`define ACM_BIT_XLAT_BLK    1
`define ACM_BIT_REQ_REDIR   2
`define ACM_BIT_CPL_REDIR   3
`define ACM_BIT_UP_FWD      4
`define ACM_BIT_EGRESS      5
`define ACM_BIT_DIRECT_XL   6

`define ACM_STRUCT_ID       16'h0012
`define ACM_STRUCT_VER      4'h1
`define ACM_MAXSETS_RST     6'h03
`define ACM_CTL_RST         7'h00
`define ACM_CAPW_RST        7'h00
`define ACM_NXT_NT_ONLY     12'h000
`define ACM_NXT_MULTI       12'h340

`endif

// File: include/acm_pkg.sv
// types for the acs control and multicast capability bank
// assumes acm_map.svh supplies all numeric constants
package acm_pkg;

    typedef enum logic [1:0] {
        ACM_MODE_NT_ONLY = 2'b00,
        ACM_MODE_MULTI_NT = 2'b01,
        ACM_MODE_MULTI_NT_DMA = 2'b10,
        ACM_MODE_RSVD = 2'b11
    } acm_mode_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } acm_req_s;

    typedef struct packed {
        logic req_redirect;
        logic cpl_redirect;
        logic direct_xlat;
    } acm_p2p_s;

endpackage : acm_pkg

// File: rtl/acm_mode_track.sv
// tracks the port operating mode and hardware default of the next pointer
// assumes mode input is already in the CLK domain
`timescale 1ns/1ps
`default_nettype none
`include "acm_map.svh"

module acm_mode_track
(
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire acm_pkg::acm_mode_e mode,
    output logic                   multi_fn,
    output logic                   mode_changed,
    output logic [11:0]            hw_next_ptr
);

    acm_pkg::acm_mode_e last_mode;

    // remember previous mode to flag a change as a pulse
    always_ff @(posedge CLK)
    begin
        if (SRST)
            last_mode <= acm_pkg::ACM_MODE_NT_ONLY;
        else
            last_mode <= mode;
    end

    assign mode_changed = (mode != last_mode);

    // multi-function modes are the two upstream-with-nt variants
    always_comb
    begin
        multi_fn = (mode == acm_pkg::ACM_MODE_MULTI_NT) || (mode == acm_pkg::ACM_MODE_MULTI_NT_DMA);
        hw_next_ptr = multi_fn ? `ACM_NXT_MULTI : `ACM_NXT_NT_ONLY; // [R9]
    end

endmodule : acm_mode_track
`default_nettype wire

// File: rtl/acm_p2p_enables.sv
// three peer-to-peer enable bits gated by their capability bits
// assumes write strobe and data arrive on CLK
`timescale 1ns/1ps
`default_nettype none
`include "acm_map.svh"

module acm_p2p_enables
(
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire logic              wr_en,
    input  wire acm_pkg::acm_p2p_s wr_val,
    input  wire acm_pkg::acm_p2p_s cap,
    output acm_pkg::acm_p2p_s      en
);

    acm_pkg::acm_p2p_s stored;

    // a bit can only hold a one while its capability is present
    always_ff @(posedge CLK)
    begin
        if (SRST)
            stored <= '0;
        else if (wr_en)
            stored <= wr_val & cap; // [R4]
        else
            stored <= stored & cap; // [R4]
    end

    assign en = stored & cap; // [R4]

endmodule : acm_p2p_enables
`default_nettype wire

// File: rtl/acm_regs.sv
// configuration register bank: acs control word, multicast header and capability word
// assumes a single-cycle strobe register port on CLK; mode pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "acm_map.svh"

// Behaviour
// [R1] request redirect enable drives REQ_REDIRECT output
// [R2] completion redirect enable drives CPL_REDIRECT output
// [R3] direct translated enable drives DIRECT_XLAT output
// [R4] enables read zero when capability bit clear
// [R5] validation, blocking, forwarding enables read zero
// [R6] egress control enable reads zero
// [R7] header low half returns identifier 0x12
// [R8] header bits 19:16 return version 1
// [R9] next pointer defaults by operating mode
// [R10] written next pointer survives mode changes
// [R11] max sets resets 3, locked, survives soft reset
// [R12] ecrc regeneration bit reads zero
// [R13] capability bits settable only in multi-function mode
// [R14] reserved and read-only writes ignored, read zero
module acm_regs
#(
    parameter int ADDR_W = `ACM_ADDR_W
)
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        SOFT_RST,
    input  wire logic [1:0]  PORT_MODE,
    input  wire logic [11:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    output logic             REQ_REDIRECT,
    output logic             CPL_REDIRECT,
    output logic             DIRECT_XLAT,
    output logic [5:0]       MAX_SETS
);

    // the port decoder is fixed at twelve bits; refuse anything else at elaboration
    if (ADDR_W != 12)
    begin : g_addr_w_chk
        $error("acm_regs: ADDR_W must be 12");
    end

    acm_pkg::acm_req_s   req;
    acm_pkg::acm_mode_e  mode;
    acm_pkg::acm_p2p_s   cap;
    acm_pkg::acm_p2p_s   wr_p2p;
    acm_pkg::acm_p2p_s   en;
    logic [1:0]          mode_meta;
    logic [1:0]          mode_sync;
    logic                multi_fn;
    logic                mode_changed;
    logic [11:0]         hw_next_ptr;
    logic [11:0]         sw_next_ptr;
    logic                sw_next_valid;
    logic [5:0]          max_sets;
    logic                lock_open;
    logic                wr_ctl;
    logic                wr_hdr;
    logic                wr_cap;
    logic                wr_mode_cfg;
    logic                wr_lock;
    logic [11:0]         next_ptr;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // word-aligned decode shared by all write enables
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    assign wr_ctl      = req.wr && hit(req.addr, `ACM_OFF_ACS_CTL);
    assign wr_hdr      = req.wr && hit(req.addr, `ACM_OFF_MC_HDR);
    assign wr_cap      = req.wr && hit(req.addr, `ACM_OFF_MC_CAP);
    assign wr_mode_cfg = req.wr && hit(req.addr, `ACM_OFF_MODE_CFG);
    assign wr_lock     = req.wr && hit(req.addr, `ACM_OFF_LOCK);

    // mode pin comes from straps outside the clock domain
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            mode_meta <= 2'h0;
            mode_sync <= 2'h0;
        end
        else
        begin
            mode_meta <= PORT_MODE;
            mode_sync <= mode_meta;
        end
    end

    assign mode = acm_pkg::acm_mode_e'(mode_sync);

    acm_mode_track u_mode
    (
        .CLK          (CLK),
        .SRST         (SRST),
        .mode         (mode),
        .multi_fn     (multi_fn),
        .mode_changed (mode_changed),
        .hw_next_ptr  (hw_next_ptr)
    );

    // lock register opens locked-writable fields; cleared by write of zero
    always_ff @(posedge CLK)
    begin
        if (SRST)
            lock_open <= 1'b0;
        else if (wr_lock)
            lock_open <= req.wdata[0];
    end

    // capability bits: acs capability word sits in the upper half of 0x324
    // they fall back to zero whenever the port leaves multi-function mode
    always_ff @(posedge CLK)
    begin
        if (SRST)
            cap <= '0;
        else if (!multi_fn)
            cap <= '0; // [R13]
        else if (wr_ctl && lock_open)
        begin
            cap.req_redirect <= req.wdata[16 + `ACM_BIT_REQ_REDIR];
            cap.cpl_redirect <= req.wdata[16 + `ACM_BIT_CPL_REDIR];
            cap.direct_xlat  <= req.wdata[16 + `ACM_BIT_DIRECT_XL];
        end
    end

    // only the three writable enables are taken; other bits dropped
    always_comb
    begin
        wr_p2p.req_redirect = req.wdata[`ACM_BIT_REQ_REDIR];
        wr_p2p.cpl_redirect = req.wdata[`ACM_BIT_CPL_REDIR];
        wr_p2p.direct_xlat  = req.wdata[`ACM_BIT_DIRECT_XL]; // [R14]
    end

    acm_p2p_enables u_en
    (
        .CLK    (CLK),
        .SRST   (SRST),
        .wr_en  (wr_ctl),
        .wr_val (wr_p2p),
        .cap    (cap),
        .en     (en)
    );

    // enables steer the peer-to-peer routing datapath
    assign REQ_REDIRECT = en.req_redirect; // [R1]
    assign CPL_REDIRECT = en.cpl_redirect; // [R2]
    assign DIRECT_XLAT  = en.direct_xlat;  // [R3]

    // next pointer: software value kept once written, mode changes ignored
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sw_next_valid <= 1'b0;
            sw_next_ptr   <= 12'h000;
        end
        else if (wr_hdr && lock_open)
        begin
            sw_next_valid <= 1'b1; // [R10]
            sw_next_ptr   <= req.wdata[31:20];
        end
    end

    // hardware default tracks mode until software takes over
    assign next_ptr = sw_next_valid ? sw_next_ptr : hw_next_ptr; // [R9] [R10]

    // max sets: soft reset does not touch it, only the hard reset
    always_ff @(posedge CLK)
    begin
        if (SRST)
            max_sets <= `ACM_MAXSETS_RST; // [R11]
        else if (wr_cap && lock_open)
            max_sets <= req.wdata[5:0]; // [R11]
    end

    assign MAX_SETS = max_sets;

    // read data registered, valid from the cycle after the strobe and held until the next read
    always_ff @(posedge CLK)
    begin
        if (SRST)
            RDATA <= 32'h0000_0000;
        else if (req.rd)
        begin
            RDATA <= 32'h0000_0000;
            if (hit(req.addr, `ACM_OFF_ACS_CTL))
            begin
                RDATA[16 + `ACM_BIT_REQ_REDIR] <= cap.req_redirect;
                RDATA[16 + `ACM_BIT_CPL_REDIR] <= cap.cpl_redirect;
                RDATA[16 + `ACM_BIT_DIRECT_XL] <= cap.direct_xlat;
                RDATA[`ACM_BIT_REQ_REDIR]      <= en.req_redirect; // [R4]
                RDATA[`ACM_BIT_CPL_REDIR]      <= en.cpl_redirect; // [R4]
                RDATA[`ACM_BIT_DIRECT_XL]      <= en.direct_xlat;  // [R4]
                // validation, blocking, forwarding, egress and 15:7 stay zero
                RDATA[`ACM_BIT_SRC_VAL]        <= 1'b0; // [R5]
                RDATA[`ACM_BIT_XLAT_BLK]       <= 1'b0; // [R5]
                RDATA[`ACM_BIT_UP_FWD]         <= 1'b0; // [R5]
                RDATA[`ACM_BIT_EGRESS]         <= 1'b0; // [R6]
            end
            else if (hit(req.addr, `ACM_OFF_MC_HDR))
                RDATA <= {next_ptr, `ACM_STRUCT_VER, `ACM_STRUCT_ID}; // [R7] [R8]
            else if (hit(req.addr, `ACM_OFF_MC_CAP))
                RDATA <= {16'h0000, 1'b0, 9'h000, max_sets}; // [R12] [R14]
            else if (hit(req.addr, `ACM_OFF_MODE_CFG))
                RDATA <= {28'h0000000, mode_changed, multi_fn, mode_sync};
            else if (hit(req.addr, `ACM_OFF_LOCK))
                RDATA <= {31'h00000000, lock_open};
        end
    end

    // soft reset input is accepted but preserves every field here
    logic unused_soft;
    assign unused_soft = SOFT_RST | wr_mode_cfg;

endmodule : acm_regs
`default_nettype wire

// File: verif/acm_regs_sva.sv
// assertions on the register bank ports
// assumes word decode on ADDR[11:2]; bound to acm_regs below
`timescale 1ns/1ps
`default_nettype none
module acm_regs_chk
(
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic [1:0]  PORT_MODE,
    input wire logic [11:0] ADDR,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        REQ_REDIRECT,
    input wire logic        CPL_REDIRECT,
    input wire logic        DIRECT_XLAT,
    input wire logic [5:0]  MAX_SETS
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    // reads of the control, header and capability words, enable pins gathered
    wire logic       rc = RD && ADDR[11:2] == 10'h0C9;
    wire logic       rh = RD && ADDR[11:2] == 10'h0CC;
    wire logic       rm = RD && ADDR[11:2] == 10'h0CD;
    wire logic [2:0] en = {DIRECT_XLAT, CPL_REDIRECT, REQ_REDIRECT};
    AST_CTL_RO: assert property (rc |=> {RDATA[15:7], RDATA[5:4], RDATA[1:0]} == 13'h0000)
        else $error("control read-only bits set");
    AST_EN_RD: assert property (rc |=> {RDATA[6], RDATA[3:2]} == $past(en))
        else $error("enable pins differ from readback");
    AST_EN_CAP: assert property (rc |=> ({RDATA[6], RDATA[3:2]} & ~{RDATA[22], RDATA[19:18]}) == 3'h0)
        else $error("enable set without capability");
    // sync and clearing fit in five cycles
    AST_CAP_MODE: assert property ((!(^PORT_MODE))[*5] ##0 rc |=> {RDATA[22], RDATA[19:18]} == 3'h0)
        else $error("capability set outside multi mode");
    AST_HDR: assert property (rh |=> RDATA[19:0] == 20'h10012)
        else $error("header id or version wrong");
    AST_MC_RO: assert property (rm |=> RDATA[15:6] == 10'h000)
        else $error("multicast read-only bits set");
    AST_MAX_RD: assert property (rm && !$past(WR) |=> RDATA[5:0] == $past(MAX_SETS))
        else $error("max sets readback differs");
    AST_MAX_KEEP: assert property (!WR && !$past(WR) |=> $stable(MAX_SETS))
        else $error("max sets moved without write");
endmodule : acm_regs_chk
bind acm_regs acm_regs_chk u_chk (.CLK, .SRST, .PORT_MODE, .ADDR, .WR, .RD, .RDATA,
    .REQ_REDIRECT, .CPL_REDIRECT, .DIRECT_XLAT, .MAX_SETS);
`default_nettype wire

// File: verif/acm_host.sv
// host configuration master on the register port
// assumes one-cycle strobes, read data in the cycle after
`timescale 1ns/1ps
`default_nettype none
module acm_host
(
    input  wire logic        CLK,
    input  wire logic [31:0] RDATA,
    output logic [11:0]      ADDR,
    output logic [31:0]      WDATA,
    output logic             WR,
    output logic             RD
);
    // idle bus shows junk, never a stale value
    initial
    begin
        ADDR  = 12'hFFF;
        WDATA = 32'hFFFFFFFF;
        WR    = 1'b0;
        RD    = 1'b0;
    end
    // extra edge so strobes never double up
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
        ADDR  <= ~a;
        WDATA <= ~d;
        @(posedge CLK);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        ADDR <= ~a;
        @(posedge CLK);
        d = RDATA;
    endtask : rd
endmodule : acm_host
`default_nettype wire

// File: verif/acm_regs_tb.sv
// self-checking bench for acm_regs
// assumes host model on the register port, checker bound
`timescale 1ns/1ps
`default_nettype none
module acm_regs_tb;
    logic        CLK = 1'b0;
    logic        SRST = 1'b1;
    logic        SOFT_RST = 1'b0;
    logic [1:0]  PORT_MODE = 2'h0;
    logic [11:0] ADDR;
    logic [31:0] WDATA, RDATA, d;
    logic        WR, RD, REQ_REDIRECT, CPL_REDIRECT, DIRECT_XLAT;
    logic [5:0]  MAX_SETS;
    logic [31:0] r = 32'h00013AAE;
    int          n_fail = 0;
    int          n_checks = 0;
    always #10 CLK = ~CLK;
    acm_regs dut (.CLK, .SRST, .SOFT_RST, .PORT_MODE, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .REQ_REDIRECT, .CPL_REDIRECT, .DIRECT_XLAT, .MAX_SETS);
    acm_host h (.CLK, .RDATA, .ADDR, .WDATA, .WR, .RD);
    // lfsr stimulus; expected word gates enables by capability
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    function automatic logic [31:0] acs(input logic [31:0] x);
        return (x & 32'h004C0000) | (x & (x >> 16) & 32'h0000004C);
    endfunction : acs
    // enable pins: each enable bit gated by its capability bit
    function automatic logic [31:0] en3(input logic [31:0] x);
        return {29'h0, x[6] & x[22], x[3:2] & x[19:18]};
    endfunction : en3
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
            $display("ERROR %0t got %h exp %h", $time, g, e);
        if (g !== e)
            n_fail++;
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        h.rd(a, v);
        chk(v, e);
    endtask : rchk
    // mode pin crosses a two-stage sync
    task automatic mode(input logic [1:0] m);
        PORT_MODE <= m;
        repeat (6) @(posedge CLK);
    endtask : mode
    task automatic summarize;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // tests take under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge CLK);
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        chk(32'(MAX_SETS), 32'h3);
        rchk(12'h324, 32'h0);
        rchk(12'h330, 32'h00010012);
        rchk(12'h334, 32'h3);
        mode(2'h1);
        rchk(12'h330, 32'h34010012);
        h.wr(12'h324, 32'h004C004C);
        rchk(12'h324, 32'h0);
        h.wr(12'h3F4, 32'h1);
        $display("reset test done");
        // corners first, then random; dma mode in second half
        for (int i = 0; i < 30; i++)
        begin
            if (i == 15)
                mode(2'h2);
            d = i == 0 ? 32'hFFFFFFFF : i == 1 ? 32'h0044FF04 : r;
            r = nxt(r);
            h.wr(12'h324, d);
            h.wr(12'h324, d);
            rchk(12'h324, acs(d));
            chk({29'h0, DIRECT_XLAT, CPL_REDIRECT, REQ_REDIRECT}, en3(d));
        end
        // reserved mode is not a multi-function mode: capability must drop
        mode(2'h3);
        rchk(12'h324, 32'h0);
        mode(2'h0);
        h.wr(12'h326, 32'hFFFFFFFF);
        rchk(12'h326, 32'h0);
        chk({29'h0, DIRECT_XLAT, CPL_REDIRECT, REQ_REDIRECT}, 32'h0);
        $display("enable test done");
        h.wr(12'h330, r);
        rchk(12'h330, {r[31:20], 20'h10012});
        mode(2'h1);
        rchk(12'h330, {r[31:20], 20'h10012});
        h.wr(12'h334, r);
        rchk(12'h334, {26'h0, r[5:0]});
        SOFT_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SOFT_RST <= 1'b0;
        chk(32'(MAX_SETS), {26'h0, r[5:0]});
        h.wr(12'h3F4, 32'h0);
        h.wr(12'h334, ~r);
        h.wr(12'h330, ~r);
        rchk(12'h334, {26'h0, r[5:0]});
        rchk(12'h330, {r[31:20], 20'h10012});
        h.wr(12'h200, 32'hFFFFFFFF);
        rchk(12'h200, 32'h0);
        $display("lock test done");
        summarize();
    end
endmodule : acm_regs_tb
`default_nettype wire
